// File: design/remote_register_access_gate.sv
// remote register access gate: protocol sort, remote state and write checks
// assumes first bytes and decoded register requests arrive from a link parser
module remote_register_access_gate (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic FIRST_VALID,
  input wire logic [7:0] FIRST_BYTE,
  input wire logic [1:0] FRAMING_CFG,
  input wire logic REMOTE_REQ,
  input wire logic REMOTE_ON,
  input wire logic REMOTE_BLOCK,
  input wire rgate_pkg::req_t REQ,
  input wire logic ERR_QUERY,
  input wire logic [15:0] ACTUAL_IN,
  output rgate_pkg::rsp_t RSP,
  output logic [1:0] PROTO,
  output logic REMOTE,
  output logic [15:0] ACTUAL_OUT,
  output logic [15:0] SET_OUT,
  output logic SET_STB
);
  import rgate_pkg::*;

  // ==========================================================================
  // protocol sort on the first byte of each message
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_BIN = 3'b010,
    PS_TEXT = 3'b100
  } pstate_t;

  pstate_t ps_r, ps_nxt;
  logic comm_err;

  // framing settings are accepted but never looked at: the link is byte exact
  logic unused_framing;
  assign unused_framing = ^FRAMING_CFG;

  always_comb begin
    ps_nxt = ps_r;
    comm_err = 1'b0;
    if (FIRST_VALID) begin
      if (FIRST_BYTE == BIN_ADDR) begin
        ps_nxt = PS_BIN;
      end else if (FIRST_BYTE <= ERR_HIGH) begin
        ps_nxt = PS_IDLE;
        comm_err = 1'b1;
      end else begin
        ps_nxt = PS_TEXT;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ps_r <= PS_IDLE;
    end else begin
      ps_r <= ps_nxt;
    end
  end

  // state code on the port
  always_comb begin
    case (ps_r)
      PS_BIN: PROTO = 2'(PROTO_BIN);
      PS_TEXT: PROTO = 2'(PROTO_TEXT);
      PS_IDLE: PROTO = 2'(PROTO_IDLE);
      default: PROTO = 2'(PROTO_IDLE);
    endcase
  end

  // ==========================================================================
  // remote state: only an explicit request moves it, and it may be blocked
  logic remote_r, remote_nxt;

  always_comb begin
    remote_nxt = remote_r;
    if (REMOTE_REQ) begin
      if (!REMOTE_ON) begin
        remote_nxt = 1'b0;
      end else if (!REMOTE_BLOCK) begin
        remote_nxt = 1'b1;
      end else begin
        remote_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      remote_r <= 1'b0;
    end else begin
      remote_r <= remote_nxt;
    end
  end

  assign REMOTE = remote_r;

  // ==========================================================================
  // request check: access class, remote state, value ranges
  logic acc_ok, range_ok, accept;
  logic [7:0] err_code;

  always_comb begin
    // write-only registers give no real data back; reads of them are refused
    if (REQ.write) begin
      acc_ok = (REQ.acc == ACC_WO) || (REQ.acc == ACC_RW);
    end else begin
      acc_ok = (REQ.acc == ACC_RO) || (REQ.acc == ACC_RW);
    end
    range_ok = 1'b1;
    if (REQ.write && REQ.is_setval) begin
      if (REQ.data > SET_CEILING) begin
        range_ok = 1'b0;
      end
      if (REQ.data < REQ.lim_min || REQ.data > REQ.lim_max) begin
        range_ok = 1'b0;
      end
    end
    accept = acc_ok && range_ok && (!REQ.write || remote_r);
    err_code = {6'h00, !range_ok, !(acc_ok && (!REQ.write || remote_r))};
  end

  // ==========================================================================
  // error queue: filled silently, drained only by an error query
  logic [7:0] head_code;
  logic q_not_empty;
  logic q_push, q_pop;

  assign q_push = (REQ.valid && !accept) || comm_err;
  assign q_pop = ERR_QUERY && ps_r == PS_TEXT;

  err_queue u_errq (
    .CLK(CLK),
    .RSTN(RSTN),
    .push(q_push),
    .push_code(comm_err ? 8'hFF : err_code),
    .pop(q_pop),
    .head_code(head_code),
    .not_empty(q_not_empty)
  );

  // ==========================================================================
  // reply, set value and actual value registers
  rsp_t rsp_r, rsp_nxt;
  logic [15:0] set_r, set_nxt, act_r;
  logic set_stb_r, set_stb_nxt;

  always_comb begin
    rsp_nxt = '0;
    set_nxt = set_r;
    set_stb_nxt = 1'b0;
    if (comm_err) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.kind = RPL_COMM_ERR;
    end else if (q_pop) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.kind = RPL_ERR_INFO;
      rsp_nxt.data = q_not_empty ? {8'h00, head_code} : 16'h0000;
    end else if (REQ.valid) begin
      rsp_nxt.valid = 1'b1;
      if (accept) begin
        rsp_nxt.kind = RPL_OK;
        // binary mode answers refusals itself; text mode stays quiet
        rsp_nxt.data = REQ.write ? REQ.data : act_r;
        if (REQ.write && REQ.is_setval) begin
          set_nxt = REQ.data;
          set_stb_nxt = 1'b1;
        end
      end else if (ps_r == PS_TEXT) begin
        rsp_nxt = '0;
      end else begin
        rsp_nxt.kind = RPL_REFUSED;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rsp_r <= '0;
      set_r <= 16'h0000;
      set_stb_r <= 1'b0;
      act_r <= 16'h0000;
    end else begin
      rsp_r <= rsp_nxt;
      set_r <= set_nxt;
      set_stb_r <= set_stb_nxt;
      act_r <= ACTUAL_IN;
    end
  end

  assign RSP = rsp_r;
  assign SET_OUT = set_r;
  assign SET_STB = set_stb_r;
  assign ACTUAL_OUT = act_r;

  // ==========================================================================
  // checks
  AST_NO_WRITE_LOCAL: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.valid && REQ.write && !remote_r && !comm_err && !q_pop |=> !set_stb_r && rsp_r.kind != RPL_OK)
    else $error("write accepted outside remote control");
  AST_RANGE_HIGH: assert property (@(posedge CLK) disable iff (!RSTN)
    set_stb_r |-> set_r <= SET_CEILING)
    else $error("set value above ceiling accepted");
  AST_LIMITS: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.valid && REQ.write && REQ.is_setval && REQ.data > REQ.lim_max |=> !set_stb_r)
    else $error("set value above limit accepted");
  AST_NO_IMPLICIT: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(remote_r) |-> $past(REMOTE_REQ && REMOTE_ON && !REMOTE_BLOCK))
    else $error("remote entered without an accepted request");
  AST_REMOTE_STABLE: assert property (@(posedge CLK) disable iff (!RSTN)
    !REMOTE_REQ |=> $stable(remote_r))
    else $error("remote state changed without a request");
  AST_DENY: assert property (@(posedge CLK) disable iff (!RSTN)
    REMOTE_REQ && REMOTE_BLOCK && !remote_r |=> !remote_r)
    else $error("blocked activation entered remote");
  AST_CLASS: assert property (@(posedge CLK) disable iff (!RSTN)
    REQ.valid && !REQ.write && REQ.acc == ACC_WO && !comm_err && !q_pop |=> rsp_r.kind != RPL_OK)
    else $error("read of write-only register answered");
  AST_SORT: assert property (@(posedge CLK) disable iff (!RSTN)
    FIRST_VALID && FIRST_BYTE >= TEXT_LOW |=> PROTO == 2'(PROTO_TEXT))
    else $error("text message not recognised");
  AST_COMM_ERR: assert property (@(posedge CLK) disable iff (!RSTN)
    FIRST_VALID && FIRST_BYTE != BIN_ADDR && FIRST_BYTE <= ERR_HIGH |=> rsp_r.kind == RPL_COMM_ERR)
    else $error("bad first byte not flagged");
  AST_TEXT_QUIET: assert property (@(posedge CLK) disable iff (!RSTN)
    ps_r == PS_TEXT && !ERR_QUERY && !comm_err |=> rsp_r.kind != RPL_REFUSED && rsp_r.kind != RPL_ERR_INFO)
    else $error("unsolicited error in text mode");

endmodule : remote_register_access_gate

// File: pkg/rgate_pkg.sv
// package for the remote register access gate
// assumes a byte stream from a virtual serial link, one byte per strobe
package rgate_pkg;

  // ==========================================================================
  // scaling
  localparam logic [15:0] FULL_SCALE = 16'hCCCC;     // code for 100 % nominal
  localparam logic [15:0] SET_CEILING = 16'hD0E5;    // code for 102 % nominal

  // ==========================================================================
  // first-byte classification
  localparam logic [7:0] BIN_ADDR = 8'h00;
  localparam logic [7:0] ERR_HIGH = 8'h29;           // 41
  localparam logic [7:0] TEXT_LOW = 8'h2A;           // 42

  // ==========================================================================
  // register access classes and data type widths
  typedef enum logic [1:0] {
    ACC_RO = 2'b01,
    ACC_WO = 2'b10,
    ACC_RW = 2'b11
  } access_t;

  typedef enum logic [2:0] {
    DT_CHAR = 3'h0,
    DT_U8 = 3'h1,
    DT_U16 = 3'h2,
    DT_U32 = 3'h3,
    DT_FLOAT = 3'h4
  } dtype_t;

  localparam logic [3:0] REG_WORD_BYTES = 4'h2;

  // ==========================================================================
  // state codes and reply kinds
  localparam int unsigned PROTO_IDLE = 0;
  localparam int unsigned PROTO_BIN = 1;
  localparam int unsigned PROTO_TEXT = 2;

  typedef enum logic [2:0] {
    RPL_NONE = 3'h0,
    RPL_OK = 3'h1,
    RPL_REFUSED = 3'h2,
    RPL_COMM_ERR = 3'h3,
    RPL_ERR_INFO = 3'h4
  } reply_t;

  // incoming decoded request (one register access)
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
    access_t acc;
    logic is_setval;
    logic [15:0] lim_min;
    logic [15:0] lim_max;
  } req_t;

  // reply summary
  typedef struct packed {
    logic valid;
    reply_t kind;
    logic [15:0] data;
  } rsp_t;

endpackage : rgate_pkg

// File: design/err_queue.sv
// small error queue memory, registered read data
// assumes one writer and one reader in the same clock domain
module err_queue (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic push,
  input wire logic [7:0] push_code,
  input wire logic pop,
  output logic [7:0] head_code,
  output logic not_empty
);
  import rgate_pkg::*;

  logic [7:0] mem [0:7];
  logic [2:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] head_r;

  // ==========================================================================
  // pointers; a full queue drops new codes, oldest ones are kept
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push && cnt_r != 4'h8) begin
      wp_nxt = wp_r + 3'h1;
      cnt_nxt = cnt_nxt + 4'h1;
    end
    if (pop && cnt_r != 4'h0) begin
      rp_nxt = rp_r + 3'h1;
      cnt_nxt = cnt_nxt - 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage and registered read of the entry that is the head after this edge;
  // a code written into that very slot bypasses the memory, which still holds
  // the old word at this edge, so back-to-back pops never show a stale head
  always_ff @(posedge CLK) begin
    if (push && cnt_r != 4'h8) begin
      mem[wp_r] <= push_code;
    end
    if (push && cnt_r != 4'h8 && wp_r == rp_nxt) begin
      head_r <= push_code;
    end else begin
      head_r <= mem[rp_nxt];
    end
  end

  assign head_code = head_r;
  assign not_empty = (cnt_r != 4'h0);

endmodule : err_queue

// File: dv/host_model.sv
// host-side partner: starts messages, asks for remote control, sends register requests
// assumes the bench calls its tasks from one process; clk comes from the bench
module host_model (
  input wire logic clk,
  output logic first_valid,
  output logic [7:0] first_byte,
  output logic remote_req,
  output logic remote_on,
  output rgate_pkg::req_t req,
  output logic err_query
);
  timeunit 1ns;
  timeprecision 1ns;
  import rgate_pkg::*;

  // ==========================================================================
  // idle levels; released lines show the inverse, never a stale value
  initial begin
    first_valid = 1'b0;
    first_byte = 8'hA5;
    remote_req = 1'b0;
    remote_on = 1'b0;
    req = '0;
    err_query = 1'b0;
  end

  // natural rounding: may land one code above the truncated value
  function automatic logic [15:0] pct_code(input int unsigned val, input int unsigned nominal);
    return 16'((52428 * val + nominal / 2) / nominal);
  endfunction : pct_code

  // every request rises after an edge and drops just after the taking edge
  task automatic start_msg(input logic [7:0] b);
    @(posedge clk) #1;
    first_valid = 1'b1;
    first_byte = b;
    @(posedge clk) #1;
    first_valid = 1'b0;
    first_byte = ~b;
  endtask : start_msg

  // activation is its own step, never folded into a write
  task automatic remote(input logic on);
    @(posedge clk) #1;
    remote_req = 1'b1;
    remote_on = on;
    @(posedge clk) #1;
    remote_req = 1'b0;
    remote_on = ~on;
  endtask : remote

  // the released word is built first so the bus is written once per step
  task automatic access(input req_t r);
    req_t rel;
    rel = ~r;
    rel.valid = 1'b0;
    @(posedge clk) #1;
    req = r;
    @(posedge clk) #1;
    req = rel;
  endtask : access

  task automatic query();
    @(posedge clk) #1;
    err_query = 1'b1;
    @(posedge clk) #1;
    err_query = 1'b0;
  endtask : query
endmodule : host_model

// File: dv/remote_register_access_gate_bench.sv
// self-checking bench for the remote register access gate
// assumes the host model drives all request inputs; bench drives the levels
module remote_register_access_gate_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rgate_pkg::*;

  logic clk, rstn, first_valid, remote_req, remote_on, remote_block, err_query, remote, set_stb;
  logic [7:0] first_byte, b;
  logic [1:0] framing_cfg, proto;
  logic [15:0] actual_in, actual_out, set_out, last;
  req_t req, r;
  rsp_t rsp;
  int bad_count, checks, cycles;

  // ==========================================================================
  // clock, design and partner
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  host_model i_host_model (.clk(clk), .first_valid(first_valid), .first_byte(first_byte),
    .remote_req(remote_req), .remote_on(remote_on), .req(req), .err_query(err_query));

  remote_register_access_gate i_remote_register_access_gate (.CLK(clk), .RSTN(rstn),
    .FIRST_VALID(first_valid), .FIRST_BYTE(first_byte), .FRAMING_CFG(framing_cfg),
    .REMOTE_REQ(remote_req), .REMOTE_ON(remote_on), .REMOTE_BLOCK(remote_block), .REQ(req),
    .ERR_QUERY(err_query), .ACTUAL_IN(actual_in), .RSP(rsp), .PROTO(proto), .REMOTE(remote),
    .ACTUAL_OUT(actual_out), .SET_OUT(set_out), .SET_STB(set_stb));

  // ==========================================================================
  // checking helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  function automatic req_t mk(input logic w, input access_t a, input logic [15:0] d, lo, hi);
    return '{valid: 1'b1, write: w, addr: 16'($urandom), data: d, acc: a, is_setval: 1'b1,
      lim_min: lo, lim_max: hi};
  endfunction : mk

  // refusal covers remote, class, ceiling and the lim_min to lim_max window
  function automatic reply_t exp_kind(input req_t q, input logic rem);
    if (q.write && (!rem || q.acc == ACC_RO || q.data > SET_CEILING || q.data < q.lim_min ||
        q.data > q.lim_max)) return RPL_REFUSED;
    if (!q.write && q.acc == ACC_WO) return RPL_REFUSED;
    return RPL_OK;
  endfunction : exp_kind

  // binary mode: every request answers one cycle later
  task automatic do_req(input req_t q, input logic rem);
    reply_t k;
    k = exp_kind(q, rem);
    i_host_model.access(q);
    if (q.write && k == RPL_OK) last = q.data;
    chk(rsp.valid, 1'b1);
    chk(rsp.kind, k);
    chk(set_stb, q.write && k == RPL_OK);
    if (k == RPL_OK) chk(rsp.data, q.write ? q.data : actual_in);
    chk(set_out, last);
  endtask : do_req

  // hang guard, well above the planned run
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 20000) begin
        bad_count++;
        report_and_stop();
      end
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    remote_block = 1'b0;
    framing_cfg = 2'h0;
    actual_in = 16'h0000;
    bad_count = 0;
    checks = 0;
    last = 16'h0000;
    void'($urandom(98201));
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    chk(remote, 1'b0);
    chk(set_out, 16'h0000);
    // corner bytes first, then random ones, framing setting shaken throughout
    for (int i = 0; i < 24; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h29 : (i == 3) ? 8'h2A :
        (i == 4) ? 8'hFF : 8'($urandom);
      framing_cfg = 2'($urandom);
      i_host_model.start_msg(b);
      chk(proto, (b == 8'h00) ? 2'(PROTO_BIN) : (b >= TEXT_LOW) ? 2'(PROTO_TEXT) : 2'(PROTO_IDLE));
      chk(rsp.kind, (b != 8'h00 && b <= ERR_HIGH) ? RPL_COMM_ERR : RPL_NONE);
    end
    i_host_model.start_msg(8'h00);
    do_req(mk(1'b1, ACC_RW, 16'h1000, 16'h0000, 16'hFFFF), 1'b0);
    chk(remote, 1'b0);
    remote_block = 1'b1;
    i_host_model.remote(1'b1);
    chk(remote, 1'b0);
    remote_block = 1'b0;
    i_host_model.remote(1'b1);
    chk(remote, 1'b1);
    do_req(mk(1'b1, ACC_RW, SET_CEILING, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b1, ACC_WO, 16'hD0E6, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b1, ACC_WO, FULL_SCALE, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b1, ACC_RW, 16'h0FFF, 16'h1000, 16'h2000), 1'b1);
    do_req(mk(1'b1, ACC_RW, 16'h2001, 16'h1000, 16'h2000), 1'b1);
    do_req(mk(1'b1, ACC_RW, 16'h2000, 16'h1000, 16'h2000), 1'b1);
    do_req(mk(1'b1, ACC_RO, 16'h0100, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b0, ACC_WO, 16'h0100, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b0, ACC_RO, 16'h0100, 16'h0000, 16'hFFFF), 1'b1);
    do_req(mk(1'b1, ACC_RW, i_host_model.pct_code(3150, 3500), 16'h0000, 16'hFFFF), 1'b1);
    chk(set_out, 16'hB851);
    for (int i = 0; i < 80; i++) begin
      actual_in = 16'($urandom);
      r = mk(1'($urandom), access_t'(2'($urandom_range(1, 3))), 16'($urandom_range(0, 16'hE000)),
        16'($urandom_range(0, 16'h4000)), 16'($urandom_range(16'hC000, 16'hE000)));
      do_req(r, 1'b1);
      chk(actual_out, actual_in);
    end
    i_host_model.remote(1'b0);
    chk(remote, 1'b0);
    do_req(mk(1'b1, ACC_RW, 16'h0200, 16'h0000, 16'hFFFF), 1'b0);
    // text mode: drain older entries, then a refusal must stay silent until asked
    i_host_model.start_msg(TEXT_LOW);
    for (int i = 0; i < 10; i++) begin
      i_host_model.query();
    end
    chk(rsp.data, 16'h0000);
    i_host_model.access(mk(1'b1, ACC_RW, 16'h0100, 16'h0000, 16'hFFFF));
    repeat (4) begin
      chk(rsp.valid, 1'b0);
      @(posedge clk) #1;
    end
    i_host_model.query();
    chk(rsp.kind, RPL_ERR_INFO);
    chk(rsp.data, 16'h0001);
    report_and_stop();
  end
endmodule : remote_register_access_gate_bench
